// File: logic/admc_mode_regs.sv
// Purpose: mode-control register bank with attenuator ramps and soft mute
// Assumes: a serial front end hands over whole 16-bit words and byte read requests
// Notes:   all inputs are synchronous to mclk
// Functional notes
// - settings change only through the serial port
// - word bit 15 set reads, clear writes
// - register 22 ignores every write
// - two 8-bit attenuation levels, default 0 dB
// - format field selects six inputs, default I2S24
// - de-emphasis rate field plus enable, both off
// - bitstream mode reroutes rate field to FIR
// - soft mute bit, off, PCM only
// - phase invert bit, normal, all modes
// - attenuation step rate fs divided 1..8
// - converter disable bit, enabled at reset
// - bypass stereo select, monaural at reset
// - rolloff select, sharp at reset
// - zero-input automute, off, PCM and bypass
// - system reset bit starts reset operation
// - bitstream interface mode bit, off
// - filter bypass bit, internal filter default
// - single_channel_mode mode and source select bits
// - oversampling field, 64x default
// - bitstream mode reroutes oversampling to FIR
// - PCM and bitstream zero-output enables
// - attenuation loads only while load bit set
// - codes 0..14 mute, 255 no attenuation
// - read index auto-increments, wraps 7F to 0
// - soft mute ramps 255 steps at speed
`default_nettype none
module admc_mode_regs
  import admc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire admc_cmd_t  cmdIn,
  input  wire logic       readReq,
  input  wire logic       sampleTick,
  input  wire logic       leftZeroIn,
  input  wire logic       rightZeroIn,
  output var  logic [7:0] readData,
  output var  logic       readValid,
  output var  admc_cfg_t  cfg,
  output var  logic [7:0] leftAttenLevel,
  output var  logic [7:0] rightAttenLevel,
  output var  logic       leftAttenMute,
  output var  logic       rightAttenMute,
  output var  logic [7:0] softMuteStep,
  output var  logic       softMuteActive,
  output var  logic       systemResetPulse
);

  logic [7:0] leftAtten;
  logic [7:0] rightAtten;
  logic [7:0] fmtCtrl;
  logic [7:0] outCtrl;
  logic [7:0] ifCtrl;
  logic [7:0] zeroEn;
  logic [7:0] zeroFlags;
  logic [6:0] regIndex;
  logic [2:0] divCount;
  logic       stepTick;
  logic       cmdWrite;
  logic       cmdRead;
  logic [6:0] cmdIndex;
  logic [7:0] cmdData;
  logic [7:0] indexedByte;
  logic [2:0] divMask;
  logic       pcmMode;
  logic [7:0] leftTarget;
  logic [7:0] rightTarget;

  // command word decode; direction bit picks read or write
  assign cmdIndex = cmdIn.word[CMD_IDX_HI:CMD_IDX_LO];
  assign cmdData  = cmdIn.word[7:0];
  assign cmdWrite = cmdIn.valid & ~cmdIn.word[CMD_DIR_BIT];
  assign cmdRead  = cmdIn.valid &  cmdIn.word[CMD_DIR_BIT];

  // attenuation levels, plain storage; loading into the ramp is gated elsewhere
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      leftAtten  <= RST_ATTEN;
      rightAtten <= RST_ATTEN;
    end
    else if (cmdWrite)
    begin
      if (cmdIndex == IDX_LEFT_ATTEN)
        leftAtten <= cmdData;
      if (cmdIndex == IDX_RIGHT_ATTEN)
        rightAtten <= cmdData;
    end
  end

  // format, de-emphasis, mute and load control; format codes 6 and 7 stored as written
  always_ff @(posedge mclk)
  begin
    if (reset)
      fmtCtrl <= RST_FMT_CTRL;
    else if (cmdWrite && cmdIndex == IDX_FMT_CTRL)
      fmtCtrl <= cmdData;
  end

  // output and filter control; bit 3 reserved
  always_ff @(posedge mclk)
  begin
    if (reset)
      outCtrl <= RST_OUT_CTRL;
    else if (cmdWrite && cmdIndex == IDX_OUT_CTRL)
      outCtrl <= cmdData & MASK_OUT_CTRL;
  end

  // interface mode control; bit 7 reserved
  always_ff @(posedge mclk)
  begin
    if (reset)
      ifCtrl <= RST_IF_CTRL;
    else if (cmdWrite && cmdIndex == IDX_IF_CTRL)
      ifCtrl <= cmdData & MASK_IF_CTRL;
  end

  // zero output enables; upper five bits reserved
  always_ff @(posedge mclk)
  begin
    if (reset)
      zeroEn <= RST_ZERO_EN;
    else if (cmdWrite && cmdIndex == IDX_ZERO_EN)
      zeroEn <= cmdData & MASK_ZERO_EN;
  end

  // zero flags follow the detectors only; writes have no path here
  always_ff @(posedge mclk)
  begin
    if (reset)
      zeroFlags <= BYTE_ZERO;
    else
      zeroFlags <= {6'h00, rightZeroIn, leftZeroIn};
  end

  // read index: a read word points it, each byte read advances it
  // a write word leaves it on the written register, so the next read returns that one
  always_ff @(posedge mclk)
  begin
    if (reset)
      regIndex <= IDX_FIRST;
    else if (cmdIn.valid)
      regIndex <= cmdIndex;
    else if (readReq)
      regIndex <= (regIndex == IDX_LAST) ? IDX_FIRST : regIndex + IDX_ONE;
  end

  // read mux; unpopulated indices return zero
  always_comb
  begin
    unique case (regIndex)
      IDX_LEFT_ATTEN:  indexedByte = leftAtten;
      IDX_RIGHT_ATTEN: indexedByte = rightAtten;
      IDX_FMT_CTRL:    indexedByte = fmtCtrl;
      IDX_OUT_CTRL:    indexedByte = outCtrl;
      IDX_IF_CTRL:     indexedByte = ifCtrl;
      IDX_ZERO_EN:     indexedByte = zeroEn;
      IDX_ZERO_FLAGS:  indexedByte = zeroFlags;
      default:         indexedByte = BYTE_ZERO;
    endcase
  end

  // read answer one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      readData  <= BYTE_ZERO;
      readValid <= 1'b0;
    end
    else
    begin
      readValid <= readReq | cmdRead;
      if (readReq | cmdRead)
        readData <= (cmdRead) ? BYTE_ZERO : indexedByte;
    end
  end

  // decoded settings; bitstream mode moves two fields onto the FIR selectors
  always_ff @(posedge mclk)
  begin
    if (reset)
      cfg <= '0;
    else
    begin
      cfg.audioFormatSel     <= fmtCtrl[B_FMT_HI:B_FMT_LO];
      cfg.deemphRateSel      <= ifCtrl[B_DSD] ? 2'b00 : fmtCtrl[B_DMF_HI:B_DMF_LO];
      cfg.firPerfSel         <= ifCtrl[B_DSD] ? fmtCtrl[B_DMF_HI:B_DMF_LO] : 2'b00;
      cfg.deemphEnable       <= fmtCtrl[B_DME];
      cfg.phaseInvert        <= outCtrl[B_REV];
      cfg.attenSpeedSel      <= outCtrl[B_ATS_HI:B_ATS_LO];
      cfg.converterDisable   <= outCtrl[B_OPE];
      cfg.bypassStereoSel    <= outCtrl[B_BYPASS_STEREO_SEL] & ifCtrl[B_FILTER_BYPASS];
      cfg.rolloffSel         <= outCtrl[B_FLT];
      cfg.zeroInputAutomute  <= outCtrl[B_ZERO_INPUT_AUTOMUTE] & ~ifCtrl[B_DSD];
      cfg.bitstreamMode      <= ifCtrl[B_DSD];
      cfg.filterBypass       <= ifCtrl[B_FILTER_BYPASS];
      cfg.singleChannelMode  <= ifCtrl[B_SINGLE_CHANNEL_MODE];
      cfg.monoSourceSel      <= ifCtrl[B_SINGLE_CHANNEL_MODE_SOURCE_SEL];
      cfg.oversampleRateSel  <= ifCtrl[B_DSD] ? 2'b00 : ifCtrl[B_OS_HI:B_OS_LO];
      cfg.firRateSel         <= ifCtrl[B_DSD] ? ifCtrl[B_OS_HI:B_OS_LO] : 2'b00;
      cfg.pcmZeroOutEn       <= zeroEn[B_PCM_ZERO_OUT_EN];
      cfg.bitstreamZeroOutEn <= zeroEn[B_DZ_HI:B_DZ_LO];
    end
  end

  // one pulse per write of the reset bit, so a held bit does not keep resetting
  always_ff @(posedge mclk)
  begin
    if (reset)
      systemResetPulse <= 1'b0;
    else
      systemResetPulse <= cmdWrite && cmdIndex == IDX_IF_CTRL && cmdData[B_SOFT_SYSTEM_RESET];
  end

  // step divider: one step every 1, 2, 4 or 8 sample ticks
  assign divMask  = 3'((4'h1 << outCtrl[B_ATS_HI:B_ATS_LO]) - 4'h1);
  assign stepTick = sampleTick && ((divCount & divMask) == DIV_ZERO);
  assign pcmMode  = ~ifCtrl[B_DSD] & ~ifCtrl[B_FILTER_BYPASS];

  always_ff @(posedge mclk)
  begin
    if (reset)
      divCount <= DIV_ZERO;
    else if (sampleTick)
      divCount <= divCount + DIV_ONE;
  end

  // targets are captured only while loading is allowed, else the old level stays
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      leftTarget  <= RST_ATTEN;
      rightTarget <= RST_ATTEN;
    end
    else if (fmtCtrl[B_LOAD_EN])
    begin
      leftTarget  <= leftAtten;
      rightTarget <= rightAtten;
    end
  end

  // applied levels walk one code per step toward the target to avoid zipper noise
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      leftAttenLevel  <= RST_ATTEN;
      rightAttenLevel <= RST_ATTEN;
    end
    else if (stepTick)
    begin
      if (leftAttenLevel < leftTarget)
        leftAttenLevel <= leftAttenLevel + STEP_ONE;
      else if (leftAttenLevel > leftTarget)
        leftAttenLevel <= leftAttenLevel - STEP_ONE;
      if (rightAttenLevel < rightTarget)
        rightAttenLevel <= rightAttenLevel + STEP_ONE;
      else if (rightAttenLevel > rightTarget)
        rightAttenLevel <= rightAttenLevel - STEP_ONE;
    end
  end

  // low codes are full mute; registered from the applied level
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      leftAttenMute  <= 1'b0;
      rightAttenMute <= 1'b0;
    end
    else
    begin
      leftAttenMute  <= leftAttenLevel <= ATTEN_MUTE_MAX;
      rightAttenMute <= rightAttenLevel <= ATTEN_MUTE_MAX;
    end
  end

  // soft mute ramp; in other modes it unwinds so leaving PCM never sticks muted
  always_ff @(posedge mclk)
  begin
    if (reset)
      softMuteStep <= BYTE_ZERO;
    else if (stepTick)
    begin
      if (fmtCtrl[B_MUTE] && pcmMode && softMuteStep != RAMP_FULL)
        softMuteStep <= softMuteStep + STEP_ONE;
      else if (!(fmtCtrl[B_MUTE] && pcmMode) && softMuteStep != BYTE_ZERO)
        softMuteStep <= softMuteStep - STEP_ONE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      softMuteActive <= 1'b0;
    else
      softMuteActive <= fmtCtrl[B_MUTE] & pcmMode;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_zero_flags_ro;
    cmdWrite && cmdIndex == IDX_ZERO_FLAGS |=> zeroFlags == {6'h00, $past(rightZeroIn), $past(leftZeroIn)};
  endproperty
  a_zero_flags_ro: assert property (p_zero_flags_ro) else $error("zero flags changed by write");

  property p_write_left;
    cmdWrite && cmdIndex == IDX_LEFT_ATTEN |=> leftAtten == $past(cmdData);
  endproperty
  a_write_left: assert property (p_write_left) else $error("left level not stored");

  property p_read_no_store;
    cmdRead |=> $stable(leftAtten) && $stable(fmtCtrl) && $stable(ifCtrl);
  endproperty
  a_read_no_store: assert property (p_read_no_store) else $error("read word altered a register");

  property p_reserved_zero;
    outCtrl[3] == 1'b0 && ifCtrl[7] == 1'b0 && zeroEn[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_index_wrap;
    readReq && !cmdIn.valid && regIndex == IDX_LAST |=> regIndex == IDX_FIRST;
  endproperty
  a_index_wrap: assert property (p_index_wrap) else $error("index did not wrap");

  property p_read_answer;
    readReq && !cmdIn.valid |=> readValid && readData == $past(indexedByte);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data wrong");

  property p_load_hold;
    !fmtCtrl[B_LOAD_EN] |=> leftTarget == $past(leftTarget);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("target moved without load");

  property p_mute_code;
    leftAttenLevel <= ATTEN_MUTE_MAX |=> leftAttenMute;
  endproperty
  a_mute_code: assert property (p_mute_code) else $error("low code not muted");

  property p_ramp_bound;
    !stepTick |=> $stable(softMuteStep) && $stable(leftAttenLevel);
  endproperty
  a_ramp_bound: assert property (p_ramp_bound) else $error("ramp moved off step");

  property p_fir_route;
    ifCtrl[B_DSD] |=> cfg.deemphRateSel == 2'b00 && cfg.firPerfSel == $past(fmtCtrl[B_DMF_HI:B_DMF_LO]);
  endproperty
  a_fir_route: assert property (p_fir_route) else $error("fir selector not routed");

  property p_soft_system_reset_pulse;
    cmdWrite && cmdIndex == IDX_IF_CTRL && cmdData[B_SOFT_SYSTEM_RESET] |=> systemResetPulse ##1 (!systemResetPulse || $past(cmdIn.valid));
  endproperty
  a_soft_system_reset_pulse: assert property (p_soft_system_reset_pulse) else $error("reset pulse wrong");

endmodule : admc_mode_regs
`default_nettype wire

// File: logic/admc_pkg.sv
// Purpose: shared constants and types for the audio converter mode-control bank
// Assumes: one clock, synchronous active-high reset
// Notes:   indices are the seven-bit register numbers carried in the command word
`default_nettype none
package admc_pkg;
  // register indices
  localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FMT_CTRL    = 7'h12;
  localparam logic [6:0] IDX_OUT_CTRL    = 7'h13;
  localparam logic [6:0] IDX_IF_CTRL     = 7'h14;
  localparam logic [6:0] IDX_ZERO_EN     = 7'h15;
  localparam logic [6:0] IDX_ZERO_FLAGS  = 7'h16;
  localparam logic [6:0] IDX_LAST        = 7'h7F;
  localparam logic [6:0] IDX_FIRST       = 7'h00;
  localparam logic [6:0] IDX_ONE         = 7'h01;
  // reset values
  localparam logic [7:0] RST_ATTEN       = 8'hFF;
  localparam logic [7:0] RST_FMT_CTRL    = 8'h50;
  localparam logic [7:0] RST_OUT_CTRL    = 8'h00;
  localparam logic [7:0] RST_IF_CTRL     = 8'h00;
  localparam logic [7:0] RST_ZERO_EN     = 8'h01;
  // writable-bit masks, reserved bits read zero
  localparam logic [7:0] MASK_OUT_CTRL   = 8'hF7;
  localparam logic [7:0] MASK_IF_CTRL    = 8'h7F;
  localparam logic [7:0] MASK_ZERO_EN    = 8'h07;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  // command word layout
  localparam int CMD_DIR_BIT = 15;
  localparam int CMD_IDX_HI  = 14;
  localparam int CMD_IDX_LO  = 8;
  // field positions, format register
  localparam int B_LOAD_EN   = 7;
  localparam int B_FMT_HI    = 6;
  localparam int B_FMT_LO    = 4;
  localparam int B_DMF_HI    = 3;
  localparam int B_DMF_LO    = 2;
  localparam int B_DME       = 1;
  localparam int B_MUTE      = 0;
  // output control register
  localparam int B_REV       = 7;
  localparam int B_ATS_HI    = 6;
  localparam int B_ATS_LO    = 5;
  localparam int B_OPE       = 4;
  localparam int B_BYPASS_STEREO_SEL      = 2;
  localparam int B_FLT       = 1;
  localparam int B_ZERO_INPUT_AUTOMUTE      = 0;
  // interface mode register
  localparam int B_SOFT_SYSTEM_RESET      = 6;
  localparam int B_DSD       = 5;
  localparam int B_FILTER_BYPASS      = 4;
  localparam int B_SINGLE_CHANNEL_MODE      = 3;
  localparam int B_SINGLE_CHANNEL_MODE_SOURCE_SEL      = 2;
  localparam int B_OS_HI     = 1;
  localparam int B_OS_LO     = 0;
  // zero enable register
  localparam int B_DZ_HI     = 2;
  localparam int B_DZ_LO     = 1;
  localparam int B_PCM_ZERO_OUT_EN      = 0;
  // attenuator codes
  localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;
  localparam logic [7:0] RAMP_FULL      = 8'hFF;
  localparam logic [7:0] STEP_ONE       = 8'h01;
  localparam logic [2:0] DIV_ZERO       = 3'h0;
  localparam logic [2:0] DIV_ONE        = 3'h1;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } admc_cmd_t;

  typedef struct packed {
    logic [2:0] audioFormatSel;
    logic [1:0] deemphRateSel;
    logic       deemphEnable;
    logic [1:0] firPerfSel;
    logic       phaseInvert;
    logic [1:0] attenSpeedSel;
    logic       converterDisable;
    logic       bypassStereoSel;
    logic       rolloffSel;
    logic       zeroInputAutomute;
    logic       bitstreamMode;
    logic       filterBypass;
    logic       singleChannelMode;
    logic       monoSourceSel;
    logic [1:0] oversampleRateSel;
    logic [1:0] firRateSel;
    logic       pcmZeroOutEn;
    logic [1:0] bitstreamZeroOutEn;
  } admc_cfg_t;
endpackage : admc_pkg
`default_nettype wire

// File: tb/admc_host_model.sv
// Purpose: host model issuing register words and byte reads to the bank
// Assumes: requests launch just after a rising edge of mclk
// Notes:   idle word lines show the inverse of the last word, never a stale copy
`default_nettype none
module admc_host_model
  import admc_pkg::*;
(
  input  wire logic       mclk,
  output var  admc_cmd_t  cmdIn,
  output var  logic       readReq,
  input  wire logic [7:0] readData,
  input  wire logic       readValid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    cmdIn = '0;
    readReq = 1'b0;
  end

  // one whole word per strobe: direction, index, data
  task automatic send_word(input logic rd, input logic [6:0] idx, input logic [7:0] data);
    @(posedge mclk);
    cmdIn <= '{valid: 1'b1, word: {rd, idx, data}};
    @(posedge mclk);
    cmdIn <= '{valid: 1'b0, word: ~{rd, idx, data}};
  endtask : send_word

  // one byte clocked out; data only counts with readValid
  task automatic read_byte(output logic [7:0] b);
    @(posedge mclk);
    readReq <= 1'b1;
    @(posedge mclk);
    readReq <= 1'b0;
    #1;
    b = (readValid === 1'b1) ? readData : 8'hXX;
  endtask : read_byte
endmodule : admc_host_model
`default_nettype wire

// File: tb/audio_dac_mode_control_regs_tb_top.sv
// Purpose: self-checking bench for the mode-control register bank
// Assumes: host model drives the command port, bench drives ticks and flags
// Notes:   ramp counts allow one or two ticks of pipeline slack, up to eight at fs/8
`default_nettype none
module audio_dac_mode_control_regs_tb_top
  import admc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       reset;
  admc_cmd_t  cmdIn;
  logic       readReq;
  logic       sampleTick;
  logic       leftZeroIn;
  logic       rightZeroIn;
  logic [7:0] readData;
  logic       readValid;
  admc_cfg_t  cfg;
  logic [7:0] leftAttenLevel;
  logic [7:0] rightAttenLevel;
  logic       leftAttenMute;
  logic       rightAttenMute;
  logic [7:0] softMuteStep;
  logic       softMuteActive;
  logic       systemResetPulse;
  int         failures;
  int         samplesChecked;
  int         pulseCount;

  admc_mode_regs u_dut (.mclk, .reset, .cmdIn, .readReq, .sampleTick, .leftZeroIn,
    .rightZeroIn, .readData, .readValid, .cfg, .leftAttenLevel, .rightAttenLevel,
    .leftAttenMute, .rightAttenMute, .softMuteStep, .softMuteActive, .systemResetPulse);
  admc_host_model u_host (.mclk, .cmdIn, .readReq, .readData, .readValid);

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // reset pulses are single-cycle, so count them as they pass
  always @(posedge mclk)
    if (systemResetPulse === 1'b1)
      pulseCount <= pulseCount + 1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // one audio sample period, then let the ramp settle
  task automatic tick;
    @(posedge mclk);
    sampleTick <= 1'b1;
    @(posedge mclk);
    sampleTick <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : tick

  // ticks until a ramp output reaches t; a stuck ramp ends the run
  task automatic tick_until(input int sel, input logic [7:0] t, output int n);
    logic [7:0] v;
    for (n = 0; n < 400; n++)
    begin
      v = (sel == 0) ? leftAttenLevel : (sel == 1) ? rightAttenLevel : softMuteStep;
      if (v === t)
        break;
      tick();
    end
    if (n == 400)
    begin
      failures++;
      results();
    end
  endtask : tick_until

  task automatic read_at(input logic [6:0] idx, output logic [7:0] b);
    u_host.send_word(1'b1, idx, 8'h00);
    u_host.read_byte(b);
  endtask : read_at

  // defaults of all seven registers in one auto-incrementing run
  task automatic scen_reset_values;
    logic [7:0] exp [7];
    logic [7:0] b;
    exp = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01, 8'h01};
    // decoded settings lag the registers by one cycle after release
    repeat (2) @(posedge mclk);
    #1;
    check(cfg.audioFormatSel, 8'h05, "format default");
    check(cfg.pcmZeroOutEn, 8'h01, "pcm zero default");
    u_host.send_word(1'b1, IDX_LEFT_ATTEN, 8'h00);
    foreach (exp[i])
    begin
      u_host.read_byte(b);
      check(b, exp[i], "reset value");
    end
  endtask : scen_reset_values

  // reserved bits masked, flag register ignores writes, read after write not advanced
  task automatic scen_masks;
    logic [7:0] b;
    logic [6:0] idx [3];
    logic [7:0] wr [3];
    logic [7:0] rd [3];
    idx = '{IDX_OUT_CTRL, IDX_IF_CTRL, IDX_ZERO_EN};
    wr = '{8'hFF, 8'hBF, 8'hFF};
    rd = '{8'hF7, 8'h3F, 8'h07};
    foreach (idx[i])
    begin
      u_host.send_word(1'b0, idx[i], wr[i]);
      u_host.read_byte(b);
      check(b, rd[i], "masked readback");
    end
    u_host.send_word(1'b0, IDX_ZERO_FLAGS, 8'hFF);
    read_at(IDX_ZERO_FLAGS, b);
    check(b, 8'h01, "flags after write");
    @(posedge mclk);
    leftZeroIn <= 1'b0;
    rightZeroIn <= 1'b1;
    repeat (3) @(posedge mclk);
    read_at(IDX_ZERO_FLAGS, b);
    check(b, 8'h02, "right flag");
    u_host.send_word(1'b0, IDX_OUT_CTRL, 8'h00);
    u_host.send_word(1'b0, IDX_IF_CTRL, 8'h00);
    u_host.send_word(1'b0, IDX_ZERO_EN, 8'h01);
  endtask : scen_masks

  // levels only move with the load bit, one code per step at the chosen rate
  task automatic scen_atten;
    int n;
    u_host.send_word(1'b0, IDX_LEFT_ATTEN, 8'h20);
    repeat (10) tick();
    check(leftAttenLevel, 8'hFF, "held without load");
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'hD0);
    tick_until(0, 8'h20, n);
    check(n >= 223 && n <= 225, 1'b1, "ramp at fs");
    check(leftAttenMute, 1'b0, "code 32 audible");
    u_host.send_word(1'b0, IDX_LEFT_ATTEN, 8'h0E);
    tick_until(0, 8'h0E, n);
    #10;
    check(leftAttenMute, 1'b1, "code 14 mutes");
    u_host.send_word(1'b0, IDX_OUT_CTRL, 8'h60);
    u_host.send_word(1'b0, IDX_RIGHT_ATTEN, 8'hF7);
    tick_until(1, 8'hF7, n);
    check(n >= 57 && n <= 72, 1'b1, "ramp at fs/8");
    check(rightAttenMute, 1'b0, "code F7 audible");
    u_host.send_word(1'b0, IDX_OUT_CTRL, 8'h00);
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h50);
  endtask : scen_atten

  // soft mute walks the full 255-step ramp and back
  task automatic scen_soft_mute;
    int n;
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h51);
    tick_until(2, 8'hFF, n);
    check(n >= 255 && n <= 257, 1'b1, "mute ramp length");
    check(softMuteActive, 1'b1, "mute active");
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h50);
    tick_until(2, 8'h00, n);
    check(n >= 255 && n <= 257, 1'b1, "unmute ramp length");
  endtask : scen_soft_mute

  // reset pulse and bitstream remapping of the rate fields
  task automatic scen_bitstream;
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h58);
    u_host.send_word(1'b0, IDX_IF_CTRL, 8'h61);
    repeat (3) @(posedge mclk);
    #1;
    check(pulseCount, 8'h01, "one reset pulse");
    check(cfg.bitstreamMode, 1'b1, "bitstream on");
    check(cfg.firRateSel, 8'h01, "fir rate");
    check(cfg.firPerfSel, 8'h02, "fir perf");
    u_host.send_word(1'b0, IDX_IF_CTRL, 8'h00);
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h50);
  endtask : scen_bitstream

  // decoded control fields other than format and the bitstream ones, bypass gating of soft mute, unmapped read and index wrap
  task automatic scen_decode;
    logic [7:0] b;
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h5F);
    u_host.send_word(1'b0, IDX_OUT_CTRL, 8'hD7);
    u_host.send_word(1'b0, IDX_IF_CTRL, 8'h1E);
    u_host.send_word(1'b0, IDX_ZERO_EN, 8'h06);
    repeat (3) @(posedge mclk);
    #1;
    check(cfg.deemphRateSel, 8'h03, "deemph rate");
    check(cfg.deemphEnable, 8'h01, "deemph enable");
    check(cfg.phaseInvert, 8'h01, "phase invert");
    check(cfg.attenSpeedSel, 8'h02, "atten speed");
    check(cfg.converterDisable, 8'h01, "converter off");
    check(cfg.bypassStereoSel, 8'h01, "bypass stereo");
    check(cfg.rolloffSel, 8'h01, "slow rolloff");
    check(cfg.zeroInputAutomute, 8'h01, "zero automute");
    check(cfg.filterBypass, 8'h01, "filter bypass");
    check({cfg.singleChannelMode, cfg.monoSourceSel}, 8'h03, "single_channel_mode and source");
    check(cfg.oversampleRateSel, 8'h02, "oversample rate");
    check({cfg.bitstreamZeroOutEn, cfg.pcmZeroOutEn}, 8'h06, "zero out enables");
    check(softMuteActive, 8'h00, "no soft mute in bypass");
    read_at(IDX_LAST, b);
    check(b, 8'h00, "unmapped reads zero");
    u_host.read_byte(b);
    check(b, 8'h00, "index wrapped");
    u_host.send_word(1'b0, IDX_FMT_CTRL, 8'h50);
    u_host.send_word(1'b0, IDX_ZERO_EN, 8'h01);
    u_host.send_word(1'b0, IDX_IF_CTRL, 8'h00);
    u_host.send_word(1'b0, IDX_OUT_CTRL, 8'h00);
  endtask : scen_decode

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    sampleTick = 1'b0;
    leftZeroIn = 1'b1;
    rightZeroIn = 1'b0;
    failures = 0;
    samplesChecked = 0;
    pulseCount = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1;
    scen_reset_values();
    scen_masks();
    scen_atten();
    scen_soft_mute();
    scen_bitstream();
    scen_decode();
    results();
  end
endmodule : audio_dac_mode_control_regs_tb_top
`default_nettype wire
